// ===== ctmwc_top.sv
// Mode, protection and bus wake control of a high-speed CAN transceiver.
// Assumes supply monitors deliver digital valid levels with hysteresis,
// the low-power receiver delivers a digital dominant level, and pins are async.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// How it works
// [RULE1] Normal mode: transmitter follows transmit data, normal receiver drives receive output.
// [RULE2] Normal mode: dominant time-out or overtemperature cut the transmitter.
// [RULE3] Normal mode: transmitter supply loss moves to forced-receive-only, transmitter off.
// [RULE4] Logic supply loss forces power-down from any mode.
// [RULE5] Normal mode entered only with select low and both supplies valid.
// [RULE6] Select low without transmitter supply gives forced-receive-only.
// [RULE7] Forced-receive-only: no transmit, normal receiver only, ground bias, no protections.
// [RULE8] Forced-receive-only: select high moves to stand-by.
// [RULE9] Power-up picks normal, forced-receive-only or stand-by from supply and select.
// [RULE10] Stand-by: only low-power receiver runs, ground bias, detections off.
// [RULE11] Select high in an active mode switches to stand-by receivers.
// [RULE12] Stand-by never goes to forced-receive-only; ignores transmitter supply.
// [RULE13] Stand-by needs the logic supply valid.
// [RULE14] Undriven select reads high, selecting stand-by.
// [RULE15] Wake shows on the receive output and the status wake bit, never changes mode.
// [RULE16] Stand-by receive output high until wake, then follows the bus.
// [RULE17] Wake is dominant, recessive, dominant, each filtered, inside one window.
// [RULE18] Wake flag clears on change to normal or logic supply loss.
// [RULE19] Long low transmit data disables transmitter until a rising edge.
// [RULE20] Receive output held high during stand-by to active mode change.
// [RULE21] Supplies are digital valid levels; state held cleared without logic supply.
module ctmwc_top #(
    parameter int WAKE_WIN_CYC = ctmwc_pkg::WAKE_WINDOW_CYC,
    parameter int DOM_TO_CYC = ctmwc_pkg::DOM_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Controller pins
    input wire logic standby_select,
    input wire logic standby_select_driven,
    input wire logic transmit_data_in,
    output logic receive_data_out,
    // Supplies, sensors and bus
    input wire logic transmitter_supply_ok,
    input wire logic logic_supply_ok,
    input wire logic overtemp,
    input wire logic bus_dominant,
    // Analog front end control
    output logic tx_enable,
    output logic tx_drive_dominant,
    output logic normal_rx_enable,
    output logic lowpower_rx_enable,
    output logic bias_mid,
    output logic bias_gnd,
    output ctmwc_pkg::ctmwc_mode_e mode
);
    import ctmwc_pkg::*;

    localparam logic [CNT_W-1:0] WIN_CNT = CNT_W'(WAKE_WIN_CYC);
    localparam logic [CNT_W-1:0] DTO_CNT = CNT_W'(DOM_TO_CYC);
    // Pin synchroniser
    logic [PIN_N-1:0] sync1;
    logic [PIN_N-1:0] sync2;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1 <= PIN_RESET;
            sync2 <= PIN_RESET;
        end else if (ce) begin
            sync1 <= {overtemp, transmit_data_in, bus_dominant, logic_supply_ok,
                      transmitter_supply_ok, standby_select_driven, standby_select};
            sync2 <= sync1;
        end
    end

    logic ctrl_sw_stby;
    logic stb_eff;
    logic vcc_s;
    logic vio_s;
    logic bus_s;
    logic txd_s;
    logic ovt_s;
    // [RULE14] Open select reads high
    assign stb_eff = (sync2[P_STBD] ? sync2[P_STB] : 1'b1) | ctrl_sw_stby;
    // [RULE21] Supplies as valid levels
    assign vcc_s = sync2[P_VCC];
    assign vio_s = sync2[P_VIO];
    assign bus_s = sync2[P_BUS];
    assign txd_s = sync2[P_TXD];
    assign ovt_s = sync2[P_OVT];
    // Mode state
    ctmwc_mode_e next_mode;
    logic [CNT_W-1:0] chg_cnt;
    logic [CNT_W-1:0] next_chg_cnt;
    always_comb begin
        next_mode = mode;
        next_chg_cnt = '0;
        unique case (mode)
            M_PDN: begin
                // [RULE9] Power-up mode pick
                if (stb_eff) begin
                    next_mode = M_STBY;
                end else if (vcc_s) begin
                    next_mode = M_NORM;
                // [RULE6] No transmitter supply
                end else begin
                    next_mode = M_FRO;
                end
            end
            M_NORM: begin
                // [RULE11] Select high to stand-by
                if (stb_eff) begin
                    next_mode = M_STBY;
                // [RULE3] Supply loss to receive-only
                end else if (!vcc_s) begin
                    next_mode = M_FRO;
                end
            end
            M_FRO: begin
                // [RULE8] Select high to stand-by
                if (stb_eff) begin
                    next_mode = M_STBY;
                // [RULE5] Both supplies for normal
                end else if (vcc_s) begin
                    next_mode = M_NORM;
                end
            end
            M_STBY: begin
                // [RULE12] Never straight to receive-only
                if (!stb_eff && vcc_s) begin
                    next_mode = M_CHG;
                end
            end
            M_CHG: begin
                // [RULE12] Falls back to stand-by
                if (stb_eff || !vcc_s) begin
                    next_mode = M_STBY;
                end else if (chg_cnt >= CHANGE_CNT - 1'b1) begin
                    next_mode = M_NORM;
                end else begin
                    next_chg_cnt = chg_cnt + 1'b1;
                end
            end
            default: next_mode = M_PDN;
        endcase
        // [RULE4] Logic supply loss wins
        // [RULE13] Stand-by needs logic supply
        if (!vio_s) begin
            next_mode = M_PDN;
            next_chg_cnt = '0;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode <= M_PDN;
            chg_cnt <= '0;
        end else if (ce) begin
            mode <= next_mode;
            chg_cnt <= next_chg_cnt;
        end
    end
    // Transmit dominant time-out, counted only in normal mode
    logic [CNT_W-1:0] to_cnt;
    logic [CNT_W-1:0] next_to_cnt;
    logic txd_to;
    logic next_txd_to;
    logic txd_prev;
    always_comb begin
        next_to_cnt = '0;
        next_txd_to = txd_to;
        // [RULE19] Low too long blocks
        if (next_mode == M_NORM && !txd_s) begin
            next_to_cnt = (to_cnt >= DTO_CNT) ? to_cnt : to_cnt + 1'b1;
            if (to_cnt >= DTO_CNT) begin
                next_txd_to = 1'b1;
            end
        end
        // [RULE19] A rising edge or logic supply loss releases
        if ((txd_s && !txd_prev) || !vio_s) begin
            next_txd_to = 1'b0;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            to_cnt <= '0;
            txd_to <= 1'b0;
            txd_prev <= 1'b1;
        end else if (ce) begin
            to_cnt <= next_to_cnt;
            txd_to <= next_txd_to;
            txd_prev <= txd_s;
        end
    end
    // Bus wake pattern detector
    ctmwc_wake_e wst;
    ctmwc_wake_e next_wst;
    logic [FLT_W-1:0] ph_cnt;
    logic [FLT_W-1:0] next_ph_cnt;
    logic [CNT_W-1:0] win_cnt;
    logic [CNT_W-1:0] next_win_cnt;
    logic wake;
    logic next_wake;
    logic ph_done;
    assign ph_done = (ph_cnt >= FILTER_CNT);
    always_comb begin
        next_wst = wst;
        next_wake = wake;
        next_ph_cnt = ph_done ? ph_cnt : ph_cnt + 1'b1;
        next_win_cnt = win_cnt + 1'b1;
        // [RULE17] Three filtered phases
        unique case (wst)
            W_IDLE: begin
                next_ph_cnt = '0;
                next_win_cnt = '0;
                if (bus_s) begin
                    next_wst = W_DOM1;
                    next_ph_cnt = FLT_W'(1);
                end
            end
            W_DOM1: begin
                if (!bus_s) begin
                    next_wst = ph_done ? W_REC : W_IDLE;
                    next_ph_cnt = FLT_W'(1);
                end
            end
            W_REC: begin
                if (bus_s) begin
                    next_wst = ph_done ? W_DOM2 : W_IDLE;
                    next_ph_cnt = FLT_W'(1);
                end
            end
            W_DOM2: begin
                if (!bus_s) begin
                    next_wst = W_IDLE;
                end else if (ph_done) begin
                    next_wst = W_IDLE;
                    next_wake = 1'b1;
                end
            end
        endcase
        // [RULE17] Whole pattern inside window
        if (wst != W_IDLE && win_cnt >= WIN_CNT) begin
            next_wst = W_IDLE;
            next_wake = wake;
        end
        // [RULE10] Detector runs only in stand-by
        // [RULE18] Leaving stand-by or power-down clears
        if (next_mode != M_STBY || mode != M_STBY) begin
            next_wst = W_IDLE;
            next_wake = 1'b0;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wst <= W_IDLE;
            ph_cnt <= '0;
            win_cnt <= '0;
            wake <= 1'b0;
        end else if (ce) begin
            wst <= next_wst;
            ph_cnt <= next_ph_cnt;
            win_cnt <= next_win_cnt;
            wake <= next_wake;
        end
    end
    // Front end controls, registered from the next state
    logic next_tx_en;
    logic next_rxd;
    always_comb begin
        // [RULE1] [RULE2] Transmit only in normal
        next_tx_en = (next_mode == M_NORM) && !next_txd_to && !ovt_s;
        next_rxd = 1'b1;
        unique case (next_mode)
            // [RULE1] [RULE7] Normal receiver output
            M_NORM, M_FRO: next_rxd = !bus_s;
            // [RULE15] [RULE16] Wake shown only here
            M_STBY: next_rxd = next_wake ? !bus_s : 1'b1;
            // [RULE20] Held high while changing
            M_CHG, M_PDN: next_rxd = 1'b1;
            default: next_rxd = 1'b1;
        endcase
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_enable <= 1'b0;
            tx_drive_dominant <= 1'b0;
            receive_data_out <= 1'b1;
            normal_rx_enable <= 1'b0;
            lowpower_rx_enable <= 1'b0;
            bias_mid <= 1'b0;
            bias_gnd <= 1'b0;
        end else if (ce) begin
            tx_enable <= next_tx_en;
            // [RULE7] Transmit data ignored unless enabled
            tx_drive_dominant <= next_tx_en && !txd_s;
            receive_data_out <= next_rxd;
            normal_rx_enable <= (next_mode == M_NORM) || (next_mode == M_FRO);
            // [RULE10] Low-power receiver in stand-by
            lowpower_rx_enable <= (next_mode == M_STBY) || (next_mode == M_CHG);
            bias_mid <= (next_mode == M_NORM);
            bias_gnd <= (next_mode != M_NORM) && (next_mode != M_PDN);
        end
    end
    // APB slave: zero wait states, read data latched in the setup cycle
    logic [31:0] rd_word;
    logic rd_err;
    logic next_sw_stby;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic wr_ok;
    assign pready = 1'b1;
    assign wr_ok = psel && penable && pwrite && (paddr == CTRL_ADDR);
    always_comb begin
        rd_word = '0;
        rd_err = 1'b0;
        if (paddr == CTRL_ADDR) begin
            rd_word[CTRL_SW_STBY_BIT] = ctrl_sw_stby;
        end else if (paddr == STATUS_ADDR) begin
            rd_word[ST_MODE_MSB:ST_MODE_LSB] = mode;
            rd_word[ST_WAKE_BIT] = wake;
            rd_word[ST_TXTO_BIT] = txd_to;
            rd_word[ST_TXEN_BIT] = tx_enable;
            rd_word[ST_OVT_BIT] = ovt_s;
        end else begin
            rd_err = 1'b1;
        end
        // Status is read-only; a write there is refused
        rd_err = rd_err || (pwrite && paddr == STATUS_ADDR);
        next_prdata = prdata;
        next_pslverr = pslverr;
        if (psel && !penable) begin
            next_prdata = pwrite ? 32'h0 : rd_word;
            next_pslverr = rd_err;
        end
        next_sw_stby = ctrl_sw_stby;
        if (wr_ok && pstrb[0]) begin
            next_sw_stby = pwdata[CTRL_SW_STBY_BIT];
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= '0;
            pslverr <= 1'b0;
            ctrl_sw_stby <= CTRL_RESET;
        end else if (ce) begin
            prdata <= next_prdata;
            pslverr <= next_pslverr;
            ctrl_sw_stby <= next_sw_stby;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence stb_req_s;
        ce && stb_eff && vio_s && (mode == M_NORM || mode == M_FRO);
    endsequence
    sequence stby_entered_s;
        mode == M_STBY && !tx_enable && lowpower_rx_enable && !normal_rx_enable;
    endsequence
    tx_only_norm_a: assert property ( // [RULE1]
        tx_enable |-> mode == M_NORM && !txd_to && bias_mid)
        else $error("transmitter on outside normal mode");
    fro_front_a: assert property ( // [RULE7]
        mode == M_FRO |-> normal_rx_enable && !lowpower_rx_enable && bias_gnd && !tx_enable)
        else $error("receive-only front end wrong");
    pdn_entry_a: assert property (ce && !vio_s |=> mode == M_PDN) // [RULE4]
        else $error("no power-down on logic supply loss");
    uv_to_fro_a: assert property ( // [RULE3]
        ce && vio_s && mode == M_NORM && !stb_eff && !vcc_s |=> mode == M_FRO && !tx_enable)
        else $error("undervoltage did not force receive-only");
    stby_entry_a: assert property (stb_req_s |=> stby_entered_s) // [RULE11]
        else $error("select high did not enter stand-by");
    stby_no_fro_a: assert property (mode == M_STBY |=> mode != M_FRO) // [RULE12]
        else $error("stand-by went to receive-only");
    stby_rxd_a: assert property (mode == M_STBY && !wake |-> receive_data_out) // [RULE16]
        else $error("receive output low before wake");
    chg_rxd_a: assert property (mode == M_CHG |-> receive_data_out) // [RULE20]
        else $error("receive output released during mode change");
    wake_mode_a: assert property ( // [RULE15]
        $rose(wake) |-> mode == M_STBY && $past(mode) == M_STBY)
        else $error("wake flag outside stand-by");
    txd_to_a: assert property (txd_to && $past(txd_to) && ce |-> !tx_enable) // [RULE19]
        else $error("transmitter on during dominant time-out");
endmodule : ctmwc_top

`default_nettype wire

// ===== ctmwc_pkg.sv
// Constants for the transceiver mode and wake controller.
// Assumes a 125 MHz system clock and an APB register bus.
package ctmwc_pkg;
    localparam int CLK_PERIOD_NS = 8;
    // Bus wake phase filter, least time
    localparam int WAKE_FILTER_NS = 500;
    localparam int WAKE_FILTER_CYC = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Whole wake sequence window, longest time
    localparam int WAKE_WINDOW_NS = 1000000;
    localparam int WAKE_WINDOW_CYC = WAKE_WINDOW_NS / CLK_PERIOD_NS;
    // Transmit dominant time-out, least time
    localparam int DOM_TIMEOUT_NS = 1000000;
    localparam int DOM_TIMEOUT_CYC =
        (DOM_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Stand-by to active mode change, longest time
    localparam int MODE_CHANGE_NS = 20000;
    localparam int MODE_CHANGE_CYC = MODE_CHANGE_NS / CLK_PERIOD_NS;

    localparam int CNT_W = 20;
    localparam int FLT_W = 8;
    localparam logic [FLT_W-1:0] FILTER_CNT = FLT_W'(WAKE_FILTER_CYC);
    localparam logic [CNT_W-1:0] CHANGE_CNT = CNT_W'(MODE_CHANGE_CYC);

    // Register map
    localparam logic [31:0] CTRL_ADDR = 32'h0000_0000;
    localparam logic [31:0] STATUS_ADDR = 32'h0000_0004;
    localparam logic CTRL_RESET = 1'h0;
    localparam int CTRL_SW_STBY_BIT = 0;
    localparam int ST_MODE_LSB = 0;
    localparam int ST_MODE_MSB = 2;
    localparam int ST_WAKE_BIT = 4;
    localparam int ST_TXTO_BIT = 5;
    localparam int ST_TXEN_BIT = 6;
    localparam int ST_OVT_BIT = 7;

    // Synchroniser lane positions
    localparam int PIN_N = 7;
    localparam int P_STB = 0;
    localparam int P_STBD = 1;
    localparam int P_VCC = 2;
    localparam int P_VIO = 3;
    localparam int P_BUS = 4;
    localparam int P_TXD = 5;
    localparam int P_OVT = 6;
    // Lanes idle at: txd high, stb high, everything else low
    localparam logic [PIN_N-1:0] PIN_RESET = 7'h21;

    typedef enum logic [2:0] {
        M_PDN = 3'b000,
        M_NORM = 3'b001,
        M_FRO = 3'b010,
        M_STBY = 3'b011,
        M_CHG = 3'b100
    } ctmwc_mode_e;

    typedef enum logic [1:0] {
        W_IDLE = 2'b00,
        W_DOM1 = 2'b01,
        W_REC = 2'b10,
        W_DOM2 = 2'b11
    } ctmwc_wake_e;
endpackage : ctmwc_pkg

// ===== ctmwc_ctrl_model.sv
// Stand-in for the protocol controller: sends 16-bit frames on transmit data
// and samples receive data once a bit. Assumes the bench loops the bus back.
`timescale 1ns/100ps
`default_nettype none
module ctmwc_ctrl_model #(
    parameter int BIT_CYC = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Bench commands
    input wire logic go,
    input wire logic hold_low,
    input wire logic [15:0] bits,
    // Transceiver pins
    input wire logic receive_data_out,
    output logic transmit_data_in,
    // Results
    output logic busy,
    output logic [15:0] rx_bits
);
    logic [15:0] sh;
    int bit_n;
    int cyc;
    // Sample at cycle 12: past the six-edge loop delay, before the next bit
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy <= 1'b0;
            sh <= 16'h0;
            rx_bits <= 16'h0;
            bit_n <= 0;
            cyc <= 0;
        end else if (!busy && go) begin
            busy <= 1'b1;
            sh <= bits;
            bit_n <= 0;
            cyc <= 0;
        end else if (busy) begin
            if (cyc == 12) begin
                rx_bits <= {rx_bits[14:0], receive_data_out};
            end
            if (cyc == BIT_CYC - 1) begin
                cyc <= 0;
                sh <= sh << 1;
                bit_n <= bit_n + 1;
                busy <= (bit_n != 15);
            end else begin
                cyc <= cyc + 1;
            end
        end
    end
    // Idle line is recessive
    assign transmit_data_in = hold_low ? 1'b0 : (busy ? sh[15] : 1'b1);
endmodule : ctmwc_ctrl_model
`default_nettype wire

// ===== can_transceiver_mode_wake_control_test.sv
// Self-checking bench for the mode and wake controller.
// Assumes the bus is dominant when either this node or a remote node drives it.
`timescale 1ns/100ps
`default_nettype none
module can_transceiver_mode_wake_control_test;
    import ctmwc_pkg::*;
    logic clk, rstn, ce, psel, penable, pwrite, pready, pslverr, err;
    logic stb, stb_drv, txd, rxd, vcc, vio, ot, remote_dom, bus_dom, go, hold_low, busy;
    logic tx_en, tx_dom, nrx, lprx, bmid, bgnd;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [15:0] bits, rx_bits;
    ctmwc_mode_e mode;
    int error_cnt, compares, a, b, c;

    always #4 clk = ~clk;
    assign bus_dom = tx_dom | remote_dom;

    ctmwc_top #(.WAKE_WIN_CYC(400), .DOM_TO_CYC(200)) ctmwc_top_i (
        .clk(clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .standby_select(stb), .standby_select_driven(stb_drv),
        .transmit_data_in(txd), .receive_data_out(rxd),
        .transmitter_supply_ok(vcc), .logic_supply_ok(vio), .overtemp(ot),
        .bus_dominant(bus_dom), .tx_enable(tx_en), .tx_drive_dominant(tx_dom),
        .normal_rx_enable(nrx), .lowpower_rx_enable(lprx), .bias_mid(bmid),
        .bias_gnd(bgnd), .mode(mode));

    ctmwc_ctrl_model ctmwc_ctrl_model_i (
        .clk(clk), .rstn(rstn), .go(go), .hold_low(hold_low), .bits(bits),
        .receive_data_out(rxd), .transmit_data_in(txd), .busy(busy),
        .rx_bits(rx_bits));

    // Front end enables {tx, normal rx, low-power rx, mid bias, ground bias}
    function automatic logic [4:0] exp_en(input ctmwc_mode_e m);
        case (m)
            M_NORM: return 5'h1a;
            M_FRO: return 5'h09;
            M_STBY: return 5'h05;
            default: return 5'h00;
        endcase
    endfunction : exp_en

    task automatic chk_bit(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s: got %b want %b", $time, what, got, exp);
        end
    endtask : chk_bit

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask : chk_word

    task automatic chk_en(input ctmwc_mode_e m);
        chk_word({27'h0, tx_en, nrx, lprx, bmid, bgnd}, {27'h0, exp_en(m)}, "front end");
    endtask : chk_en

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic wait_mode(input ctmwc_mode_e m, input int lim);
        int n;
        n = 0;
        while (mode !== m && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk_word({29'h0, mode}, {29'h0, m}, "mode");
    endtask : wait_mode

    // Held from setup until pready is seen high, then released; one idle edge
    // follows so a following call never reassigns psel in the same step
    task automatic apb(input logic wr, input logic [31:0] ad, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic bus_phase(input logic v, input int n);
        remote_dom <= v;
        cyc(n);
    endtask : bus_phase

    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        cyc(60000);
        error_cnt++;
        give_verdict();
    end

    initial begin
        clk = 0; rstn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        stb = 1; stb_drv = 1; vcc = 1; vio = 1; ot = 0; remote_dom = 0;
        go = 0; hold_low = 0; bits = 0; error_cnt = 0; compares = 0;
        ce = 1'b1;
        void'($urandom(32'hb1e3));
        cyc(10);
        rstn <= 1'b1;
        wait_mode(M_STBY, 10);
        chk_en(M_STBY);
        chk_bit(rxd, 1'b1, "rx idle");
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk_word(rd, {31'h0, CTRL_RESET}, "ctrl reset");
        apb(1'b1, CTRL_ADDR, 32'h1);
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk_word(rd, 32'h1 << CTRL_SW_STBY_BIT, "ctrl rw");
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk_word(rd, 32'h3, "status");
        apb(1'b1, STATUS_ADDR, 32'h5);
        chk_bit(err, 1'b1, "ro write err");
        apb(1'b0, 32'h40, 32'h0);
        chk_bit(err, 1'b1, "unmapped err");
        apb(1'b1, CTRL_ADDR, 32'h0);
        $display("done: reset and registers");
        // Too short phases, then a pattern that overruns the window
        bus_phase(1, 30); bus_phase(0, 30); bus_phase(1, 30); bus_phase(0, 200);
        bus_phase(1, 200); bus_phase(0, 200); bus_phase(1, 100); bus_phase(0, 500);
        chk_bit(rxd, 1'b1, "no wake rx");
        a = $urandom_range(119, 70);
        b = $urandom_range(119, 70);
        c = $urandom_range(119, 70);
        bus_phase(1, a);
        chk_bit(rxd, 1'b1, "rx before wake");
        bus_phase(0, b); bus_phase(1, c); bus_phase(0, 10);
        chk_bit(rxd, 1'b1, "wake rx rec");
        bus_phase(1, 10);
        chk_bit(rxd, 1'b0, "wake rx dom");
        bus_phase(0, 10);
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk_bit(rd[ST_WAKE_BIT], 1'b1, "wake flag");
        chk_word({29'h0, mode}, {29'h0, M_STBY}, "wake keeps mode");
        $display("done: wake");
        stb_drv <= 1'b0;
        stb <= 1'b0;
        cyc(100);
        chk_word({29'h0, mode}, {29'h0, M_STBY}, "open select");
        stb_drv <= 1'b1;
        vcc <= 1'b0;
        cyc(3000);
        chk_word({29'h0, mode}, {29'h0, M_STBY}, "no supply stays");
        vcc <= 1'b1;
        remote_dom <= 1'b1;
        cyc(100);
        chk_word({29'h0, mode}, {29'h0, M_CHG}, "changing");
        chk_bit(rxd, 1'b1, "rx held in change");
        wait_mode(M_NORM, 3000);
        cyc(10);
        chk_en(M_NORM);
        chk_bit(rxd, 1'b0, "normal rx");
        remote_dom <= 1'b0;
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk_bit(rd[ST_WAKE_BIT], 1'b0, "flag cleared");
        $display("done: stand-by to normal");
        for (int i = 0; i < 3; i++) begin
            bits <= 16'($urandom);
            go <= 1'b1;
            cyc(1);
            go <= 1'b0;
            cyc(2);
            for (int n = 0; n < 400 && busy; n++) @(posedge clk);
            chk_word({16'h0, rx_bits}, {16'h0, bits}, "loopback");
        end
        ot <= 1'b1;
        cyc(10);
        chk_bit(tx_en, 1'b0, "overtemp off");
        ot <= 1'b0;
        cyc(10);
        chk_bit(tx_en, 1'b1, "overtemp back");
        hold_low <= 1'b1;
        cyc(150);
        chk_bit(tx_en, 1'b1, "before timeout");
        cyc(100);
        chk_bit(tx_en, 1'b0, "timeout");
        bus_phase(1, 10);
        chk_bit(rxd, 1'b0, "rx in timeout");
        bus_phase(0, 50);
        chk_bit(tx_en, 1'b0, "timeout holds");
        hold_low <= 1'b0;
        cyc(10);
        chk_bit(tx_en, 1'b1, "rising re-enables");
        $display("done: normal traffic and protections");
        vcc <= 1'b0;
        wait_mode(M_FRO, 10);
        chk_en(M_FRO);
        hold_low <= 1'b1;
        cyc(10);
        chk_bit(tx_dom, 1'b0, "txd ignored");
        hold_low <= 1'b0;
        bus_phase(1, 10);
        chk_bit(rxd, 1'b0, "fro rx");
        bus_phase(0, 10);
        // Clock enable low freezes the select path and the mode
        ce <= 1'b0;
        stb <= 1'b1;
        cyc(20);
        chk_word({29'h0, mode}, {29'h0, M_FRO}, "frozen by ce");
        ce <= 1'b1;
        wait_mode(M_STBY, 10);
        chk_en(M_STBY);
        chk_bit(rxd, 1'b1, "stby rx");
        vio <= 1'b0;
        wait_mode(M_PDN, 10);
        chk_en(M_PDN);
        stb <= 1'b0;
        cyc(20);
        chk_word({29'h0, mode}, {29'h0, M_PDN}, "held down");
        vio <= 1'b1;
        wait_mode(M_FRO, 10);
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk_word(rd & 32'h17, 32'h2, "after power-up");
        $display("done: supplies");
        give_verdict();
    end
endmodule : can_transceiver_mode_wake_control_test
`default_nettype wire
